// ### core/mfs_top.v
// Object fault flags, indicator drive and register port
//
// Strobed register access and the register addresses were left to the implementer.
`include "mfs_regs.vh"
`default_nettype none
module mfs_top #(
  parameter [22:0] PULSE_CYC = `MFS_PULSE_CYC,
  parameter [16:0] TICK_CYC = `MFS_TICK_CYC
) (
  input wire CLK,
  input wire ARST_N,
  input wire CE,
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire MST_ATTEMPT,
  input wire [2:0] MST_OBJ,
  input wire [7:0] MST_SLAVE,
  input wire TBL_INIT,
  input wire TBL_HIT,
  input wire MST_RSP_GOOD,
  input wire MST_RSP_EXC,
  input wire [7:0] MST_EXC_CODE,
  input wire MST_RSP_CRC,
  input wire SLV_REQ_RX,
  input wire SLV_RSP_GOOD,
  input wire SLV_RSP_EXC,
  input wire SLV_CRC_ERR,
  input wire NET_TRAFFIC,
  input wire SRV_RUN,
  input wire LINK_UP,
  output reg MST_SEND,
  output reg MST_ABORT,
  output reg [7:0] OBJ_DISABLED,
  output wire REQ_YELLOW,
  output wire RPL_GREEN,
  output wire RPL_RED,
  output reg NET_LED,
  output reg LINK_LED
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  ////////////////////////////////////////////////////////////////
  // Register file

  reg [15:0] ctrl_reg;
  reg [15:0] tmo_reg;
  reg [7:0] dis_reg;
  reg [7:0] esel_reg;
  wire tcp_mode;
  wire wr_ctrl;
  wire wr_tmo;
  wire wr_dis;
  wire wr_esel;
  wire wr_stat;
  wire [15:0] einfo;

  assign tcp_mode = ctrl_reg[`MFS_CTRL_TCP];
  assign wr_ctrl = WR && ADDR == `MFS_OFF_CTRL;
  assign wr_tmo = WR && ADDR == `MFS_OFF_TMO;
  assign wr_dis = WR && ADDR == `MFS_OFF_DIS;
  assign wr_esel = WR && ADDR == `MFS_OFF_ESEL;
  assign wr_stat = WR && ADDR[3];

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= `MFS_RST_CTRL;
      tmo_reg <= `MFS_RST_TMO;
      dis_reg <= `MFS_RST_DIS;
      esel_reg <= 8'h00;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl_reg <= {15'h0000, WDATA[`MFS_CTRL_TCP]};
      end
      if (wr_tmo) begin
        tmo_reg <= WDATA;
      end
      if (wr_dis) begin
        dis_reg <= WDATA[7:0];
      end
      if (wr_esel) begin
        esel_reg <= WDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Master transaction and timeout

  reg state_reg;
  reg [2:0] obj_reg;
  reg [7:0] slave_reg;
  reg [16:0] tick_reg;
  reg [15:0] ms_reg;
  wire attempt;
  wire no_route;
  wire tick;
  wire timed_out;
  wire in_wait;
  wire rsp_good;
  wire rsp_exc;
  wire rsp_crc;

  assign attempt = MST_ATTEMPT && state_reg == ST_IDLE;
  assign no_route = tcp_mode && (!TBL_INIT || !TBL_HIT);
  assign in_wait = state_reg == ST_WAIT;
  assign tick = tick_reg == TICK_CYC - 17'd1;
  assign timed_out = in_wait && !MST_RSP_GOOD && !MST_RSP_EXC && !MST_RSP_CRC &&
    (tmo_reg != 16'h0000 && ms_reg >= tmo_reg || tmo_reg == 16'h0000 && tick);
  assign rsp_good = in_wait && MST_RSP_GOOD;
  assign rsp_exc = in_wait && !MST_RSP_GOOD && MST_RSP_EXC;
  assign rsp_crc = in_wait && !MST_RSP_GOOD && !MST_RSP_EXC && MST_RSP_CRC;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_IDLE;
      obj_reg <= 3'h0;
      slave_reg <= 8'h00;
      tick_reg <= 17'h00000;
      ms_reg <= 16'h0000;
      MST_SEND <= 1'b0;
      MST_ABORT <= 1'b0;
    end else if (CE) begin
      MST_SEND <= 1'b0;
      MST_ABORT <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          tick_reg <= 17'h00000;
          ms_reg <= 16'h0000;
          if (attempt) begin
            obj_reg <= MST_OBJ;
            slave_reg <= MST_SLAVE;
            if (!no_route) begin
              MST_SEND <= 1'b1;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (tick) begin
            tick_reg <= 17'h00000;
            if (ms_reg != 16'hffff) begin
              ms_reg <= ms_reg + 16'h0001;
            end
          end else begin
            tick_reg <= tick_reg + 17'h00001;
          end
          if (timed_out) begin
            MST_ABORT <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (rsp_good || rsp_exc || rsp_crc) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-object status flags

  wire [4:0] stat_w [0:7];
  wire ev_route;

  assign ev_route = attempt && no_route;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : obj_g
      reg [3:0] flag_reg;
      reg [3:0] crc_cnt_reg;
      reg [3:0] flag_next;
      wire sel_w;
      wire sel_a;
      wire clr;

      assign sel_w = obj_reg == g;
      assign sel_a = MST_OBJ == g;
      assign clr = wr_stat && ADDR[2:0] == g;
      assign stat_w[g] = {dis_reg[g], flag_reg};

      always @* begin
        flag_next = flag_reg;
        if (clr) begin
          flag_next = flag_reg & ~WDATA[3:0];
        end
        // Set wins over a software clear
        // no-reply flag
        if (timed_out && sel_w) begin
          flag_next[`MFS_ST_NOREPLY] = 1'b1;
        end
        if (ev_route && sel_a) begin
          flag_next[`MFS_ST_NOROUTE] = 1'b1;
        end
        if (rsp_crc && sel_w && !tcp_mode &&
            crc_cnt_reg >= `MFS_CRC_LIMIT - 4'h1) begin
          flag_next[`MFS_ST_CRC] = 1'b1;
        end
        if (rsp_exc && sel_w) begin
          flag_next[`MFS_ST_EXC] = 1'b1;
        end
      end

      always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          flag_reg <= 4'h0;
          crc_cnt_reg <= 4'h0;
        end else if (CE) begin
          flag_reg <= flag_next;
          if (sel_w && (rsp_good || rsp_exc)) begin
            crc_cnt_reg <= 4'h0;
          end else if (sel_w && rsp_crc && !tcp_mode && crc_cnt_reg != `MFS_CNT_MAX) begin
            crc_cnt_reg <= crc_cnt_reg + 4'h1;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Error memory per slave address

  mfs_errlog u_errlog (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .ev_noresp(timed_out),
    .ev_crc(rsp_crc && !tcp_mode),
    .ev_exc(rsp_exc),
    .ev_good(rsp_good),
    .ev_addr(slave_reg),
    .exc_code(MST_EXC_CODE),
    .rd_addr(esel_reg),
    .rd_data(einfo)
  );

  ////////////////////////////////////////////////////////////////
  // Read port

  reg [15:0] rd_next;

  always @* begin
    rd_next = 16'h0000;
    if (ADDR[3]) begin
      rd_next = {11'h000, stat_w[ADDR[2:0]]};
    end else begin
      case (ADDR)
        `MFS_OFF_CTRL: rd_next = ctrl_reg;
        `MFS_OFF_TMO: rd_next = tmo_reg;
        `MFS_OFF_DIS: rd_next = {8'h00, dis_reg};
        `MFS_OFF_ESEL: rd_next = {8'h00, esel_reg};
        `MFS_OFF_EINFO: rd_next = einfo;
        default: rd_next = 16'h0000;
      endcase
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 16'h0000;
    end else if (CE) begin
      if (RD) begin
        RDATA <= rd_next;
      end else begin
        RDATA <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Indicators

  wire trig_yel;
  wire trig_grn;
  wire trig_red;

  // yellow on request sent or received
  assign trig_yel = attempt && !no_route || SLV_REQ_RX;
  assign trig_grn = rsp_good || SLV_RSP_GOOD;
  assign trig_red = rsp_exc || timed_out || ev_route || SLV_RSP_EXC ||
    SLV_CRC_ERR && !tcp_mode;

  mfs_pulse #(.LEN(PULSE_CYC)) u_yel (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .trig(trig_yel),
    .led_reg(REQ_YELLOW)
  );

  mfs_pulse #(.LEN(PULSE_CYC)) u_grn (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .trig(trig_grn),
    .led_reg(RPL_GREEN)
  );

  mfs_pulse #(.LEN(PULSE_CYC)) u_red (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .trig(trig_red),
    .led_reg(RPL_RED)
  );

  wire net_flash;

  mfs_pulse #(.LEN(PULSE_CYC)) u_net (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .trig(NET_TRAFFIC),
    .led_reg(net_flash)
  );

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      NET_LED <= 1'b1;
      LINK_LED <= 1'b0;
      OBJ_DISABLED <= `MFS_RST_DIS;
    end else if (CE) begin
      // flash, or solid while server down
      NET_LED <= !SRV_RUN || net_flash || NET_TRAFFIC;
      LINK_LED <= LINK_UP;
      OBJ_DISABLED <= dis_reg;
    end
  end
endmodule
`default_nettype wire

// ### include/mfs_regs.vh
// Register map, field positions and timing constants of the fault/indicator block
// Summary of operation
// - No reply before slave timeout aborts the query and sets no-reply flag.
// - TCP only: unit missing from device table, or table empty, sets no-route flag.
// - Numerous serial CRC errors on an object set its repeated-CRC flag.
// - In TCP operation the repeated-CRC flag is never set.
// - Exception reply to an object's query sets its slave-exception flag.
// - Exception flag is per object; no per-register record or codes.
// - Disabled flag shows while object disabled; manager disables before reconfiguring.
// - Master: request indicator pulses yellow on each transmitted request.
// - Master: reply indicator pulses green on valid non-exception response.
// - Master: reply indicator pulses red on exception reply or timeout.
// - Slave: request indicator pulses yellow on each received request.
// - Slave: reply indicator pulses green on accepted request with normal reply.
// - Slave: reply indicator pulses red when request yields exception reply.
// - Serial slave: reply indicator pulses red on request CRC failure.
// - TCP master, no route: no yellow, red pulse on each failed attempt.
// - Traffic indicator flashes on any network traffic, otherwise mostly off.
// - Traffic indicator stays on while the TCP server is not running.
// - Link indicator lit while network link present, off when lost.
// - Per slave address keep timeout counts and last exception code.
`ifndef MFS_REGS_VH
`define MFS_REGS_VH

`define MFS_ADDR_W 4
`define MFS_DATA_W 16
`define MFS_NOBJ 8

`define MFS_OFF_CTRL 4'h0
`define MFS_OFF_TMO 4'h1
`define MFS_OFF_DIS 4'h2
`define MFS_OFF_ESEL 4'h3
`define MFS_OFF_EINFO 4'h4
`define MFS_OFF_STAT0 4'h8

`define MFS_CTRL_TCP 0

`define MFS_ST_NOREPLY 0
`define MFS_ST_NOROUTE 1
`define MFS_ST_CRC 2
`define MFS_ST_EXC 3
`define MFS_ST_DIS 4

`define MFS_RST_CTRL 16'h0000
`define MFS_RST_TMO 16'h03e8
`define MFS_RST_DIS 8'h00

`define MFS_CRC_LIMIT 4'h3
`define MFS_CNT_MAX 4'hf

// Cycle counts at the 10 ns clock: 1 ms tick, 50 ms flash
`define MFS_TICK_CYC 17'd100000
`define MFS_PULSE_CYC 23'd5000000

`endif

// ### core/mfs_pulse.v
// Retriggerable fixed-length indicator pulse
`default_nettype none
module mfs_pulse #(
  parameter [22:0] LEN = 23'd5000000
) (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire trig,
  output reg led_reg
);
  reg [22:0] cnt_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 23'h000000;
      led_reg <= 1'b0;
    end else if (ce) begin
      if (trig) begin
        cnt_reg <= LEN - 23'd1;
        led_reg <= 1'b1;
      end else if (cnt_reg != 23'h000000) begin
        cnt_reg <= cnt_reg - 23'd1;
      end else begin
        led_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### core/mfs_errlog.v
// Per slave address error memory: counts and last exception code
`include "mfs_regs.vh"
`default_nettype none
module mfs_errlog (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire ev_noresp,
  input wire ev_crc,
  input wire ev_exc,
  input wire ev_good,
  input wire [7:0] ev_addr,
  input wire [7:0] exc_code,
  input wire [7:0] rd_addr,
  output wire [15:0] rd_data
);
  // {exc code, no-response count, crc count}
  reg [15:0] mem [0:255];
  reg [15:0] cur;
  reg [15:0] upd;
  integer i;

  assign rd_data = mem[rd_addr];

  always @* begin
    cur = mem[ev_addr];
    upd = cur;
    if (ev_good) begin
      upd[7:0] = 8'h00;
    end else begin
      if (ev_noresp && cur[7:4] != `MFS_CNT_MAX) begin
        upd[7:4] = cur[7:4] + 4'h1;
      end
      if (ev_crc && cur[3:0] != `MFS_CNT_MAX) begin
        upd[3:0] = cur[3:0] + 4'h1;
      end
      if (ev_exc) begin
        upd[15:8] = exc_code;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 256; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
    end else if (ce) begin
      if (ev_noresp || ev_crc || ev_exc || ev_good) begin
        mem[ev_addr] <= upd;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/mfs_checker.sv
// Port assertions for the fault and indicator block
`default_nettype none
module mfs_checker #(
  parameter [22:0] PULSE_CYC = 23'd8,
  parameter [16:0] TICK_CYC = 17'd4
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic MST_ATTEMPT,
  input wire logic SLV_REQ_RX,
  input wire logic SLV_RSP_GOOD,
  input wire logic SLV_RSP_EXC,
  input wire logic SRV_RUN,
  input wire logic LINK_UP,
  input wire logic MST_SEND,
  input wire logic MST_ABORT,
  input wire logic REQ_YELLOW,
  input wire logic RPL_GREEN,
  input wire logic RPL_RED,
  input wire logic NET_LED,
  input wire logic LINK_LED
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_red_hold;
    RPL_RED [*8];
  endsequence
  sequence s_grn_hold;
    RPL_GREEN [*8];
  endsequence
  a_send_yellow: assert property (MST_SEND |-> REQ_YELLOW && $past(MST_ATTEMPT))
    else $error("bad send");
  a_abort_red: assert property (MST_ABORT |-> ##[0:1] RPL_RED)
    else $error("abort not red");
  a_red_len: assert property ($rose(RPL_RED) |-> s_red_hold)
    else $error("red short");
  a_grn_len: assert property ($rose(RPL_GREEN) |-> s_grn_hold)
    else $error("green short");
  a_slv_yellow: assert property (CE && SLV_REQ_RX |=> REQ_YELLOW)
    else $error("slave yellow");
  a_slv_green: assert property (CE && SLV_RSP_GOOD |=> RPL_GREEN)
    else $error("slave green");
  a_slv_red: assert property (CE && SLV_RSP_EXC |=> RPL_RED)
    else $error("slave red");
  a_net_solid: assert property ($past(CE && !SRV_RUN) |-> NET_LED)
    else $error("net light off");
  a_link_led: assert property ($past(CE && ARST_N) |-> LINK_LED == $past(LINK_UP))
    else $error("link light");
endmodule
`default_nettype wire

// ### tb/mfs_slave_model.sv
// Remote slave answering the block's master queries
`default_nettype none
module mfs_slave_model #(
  parameter [7:0] EXC = 8'h02
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic send,
  input wire logic [1:0] mode,
  input wire logic [3:0] dly,
  output logic rsp_good,
  output logic rsp_exc,
  output logic rsp_crc,
  output logic [7:0] exc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_reg;
  logic [3:0] cnt_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      {rsp_good, rsp_exc, rsp_crc} <= 3'h0;
      exc_code <= 8'h00;
    end else begin
      {rsp_good, rsp_exc, rsp_crc} <= 3'h0;
      // Code lines not held between replies
      exc_code <= ~exc_code;
      if (send) begin
        busy_reg <= 1'b1;
        cnt_reg <= dly;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        rsp_good <= mode == 2'h0;
        rsp_exc <= mode == 2'h1;
        rsp_crc <= mode == 2'h2;
        if (mode == 2'h1) begin
          exc_code <= EXC;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/mfs_tb_top.sv
// Self-checking bench for the fault and indicator block
`default_nettype none
module mfs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, att = 1'b0, tinit = 1'b1, thit = 1'b1, traf = 1'b0;
  logic sreq = 1'b0, sgood = 1'b0, sexc = 1'b0, scrc = 1'b0, srv = 1'b0, link = 1'b0;
  logic [2:0] obj = 3'h0;
  logic ce = 1'b1;
  logic [7:0] sadr = 8'h11;
  logic [1:0] mode = 2'h0;
  logic [3:0] dly = 4'h1;
  logic [15:0] rdata;
  logic [7:0] odis, ec;
  logic msend, mabort, yel, grn, red, net, lnk, rg, re, rc;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int i;
  always #5 clk = ~clk;
  mfs_top #(.PULSE_CYC(23'd8), .TICK_CYC(17'd4)) u_mfs_top (
    .CLK(clk), .ARST_N(arst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MST_ATTEMPT(att), .MST_OBJ(obj), .MST_SLAVE(sadr), .TBL_INIT(tinit),
    .TBL_HIT(thit), .MST_RSP_GOOD(rg), .MST_RSP_EXC(re), .MST_EXC_CODE(ec), .MST_RSP_CRC(rc),
    .SLV_REQ_RX(sreq), .SLV_RSP_GOOD(sgood), .SLV_RSP_EXC(sexc), .SLV_CRC_ERR(scrc),
    .NET_TRAFFIC(traf), .SRV_RUN(srv), .LINK_UP(link), .MST_SEND(msend), .MST_ABORT(mabort),
    .OBJ_DISABLED(odis), .REQ_YELLOW(yel), .RPL_GREEN(grn), .RPL_RED(red), .NET_LED(net),
    .LINK_LED(lnk)
  );
  mfs_slave_model u_mfs_slave_model (
    .clk(clk), .arst_n(arst_n), .send(msend), .mode(mode), .dly(dly), .rsp_good(rg),
    .rsp_exc(re), .rsp_crc(rc), .exc_code(ec)
  );
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask
  task automatic query(input logic [2:0] o, input logic [1:0] m);
    @(posedge clk);
    obj <= o;
    mode <= m;
    att <= 1'b1;
    @(posedge clk);
    att <= 1'b0;
    #1;
  endtask
  task automatic spulse(input logic [3:0] k);
    @(posedge clk);
    {scrc, sexc, sgood, sreq} <= k;
    @(posedge clk);
    {scrc, sexc, sgood, sreq} <= 4'h0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_net;
    cyc(3);
    chk("net", net, 1'b1);
    srv <= 1'b1;
    cyc(3);
    chk("net", net, 1'b0);
    traf <= 1'b1;
    cyc(1);
    traf <= 1'b0;
    chk("net", net, 1'b1);
    link <= 1'b1;
    cyc(2);
    chk("link", lnk, 1'b1);
    link <= 1'b0;
    cyc(2);
    chk("link", lnk, 1'b0);
  endtask
  task automatic t_regs;
    rd_reg(4'h1, 16'h03e8, "tmo");
    rd_reg(4'h0, 16'h0000, "ctrl");
    wr_reg(4'h4, 16'hffff);
    wr_reg(4'h3, 16'h0011);
    rd_reg(4'h4, 16'h0000, "einfo");
    rd_reg(4'h6, 16'h0000, "hole");
  endtask
  task automatic t_good;
    dly <= 4'h5;
    query(3'd2, 2'h0);
    chk("send", msend, 1'b1);
    chk("yel", yel, 1'b1);
    cyc(10);
    chk("grn", grn, 1'b1);
    chk("red", red, 1'b0);
    rd_reg(4'ha, 16'h0000, "st2");
    dly <= 4'h1;
  endtask
  task automatic t_exc;
    cyc(12);
    query(3'd3, 2'h1);
    cyc(10);
    chk("red", red, 1'b1);
    chk("grn", grn, 1'b0);
    rd_reg(4'hb, 16'h0008, "st3");
    rd_reg(4'ha, 16'h0000, "st2");
    rd_reg(4'h4, 16'h0200, "einfo");
    wr_reg(4'hb, 16'h000f);
    rd_reg(4'hb, 16'h0000, "clr");
  endtask
  task automatic t_tmo;
    cyc(12);
    wr_reg(4'h1, 16'h0001);
    query(3'd1, 2'h3);
    for (i = 0; i < 40 && mabort !== 1'b1; i++) cyc(1);
    chk("abort", mabort, 1'b1);
    cyc(1);
    chk("red", red, 1'b1);
    rd_reg(4'h9, 16'h0001, "st1");
    rd_reg(4'h4, 16'h0210, "einfo");
  endtask
  task automatic t_crc;
    sadr <= 8'h22;
    for (i = 0; i < 6; i++) begin
      if (i == 3) wr_reg(4'h0, 16'h0001);
      query(i < 3 ? 3'd4 : 3'd5, 2'h2);
      cyc(10);
      if (i == 1) rd_reg(4'hc, 16'h0000, "crc2");
    end
    rd_reg(4'hc, 16'h0004, "crc3");
    rd_reg(4'hd, 16'h0000, "crctcp");
    rd_reg(4'h4, 16'h0210, "einfo11");
    wr_reg(4'h3, 16'h0022);
    rd_reg(4'h4, 16'h0003, "einfo22");
    wr_reg(4'h3, 16'h0011);
    sadr <= 8'h11;
  endtask
  task automatic t_route;
    for (i = 0; i < 2; i++) begin
      tinit <= i[0];
      thit <= 1'b0;
      cyc(12);
      query(3'd6 + 3'(i), 2'h0);
      chk("send", msend, 1'b0);
      chk("yel", yel, 1'b0);
      chk("red", red, 1'b1);
      rd_reg(4'he + 4'(i), 16'h0002, "route");
    end
    wr_reg(4'h0, 16'h0000);
  endtask
  task automatic t_dis;
    wr_reg(4'h2, 16'h0081);
    cyc(1);
    chk("dis", odis, 8'h81);
    rd_reg(4'h8, 16'h0010, "st0");
    wr_reg(4'h2, 16'h0000);
  endtask
  task automatic t_slave;
    cyc(12);
    spulse(4'h3);
    chk("yel", yel, 1'b1);
    chk("grn", grn, 1'b1);
    cyc(4);
    spulse(4'h2);
    cyc(5);
    chk("grn", grn, 1'b1);
    cyc(12);
    wr_reg(4'h0, 16'h0001);
    spulse(4'h8);
    chk("redtcp", red, 1'b0);
    wr_reg(4'h0, 16'h0000);
    spulse(4'h8);
    chk("red", red, 1'b1);
    cyc(12);
    spulse(4'h4);
    chk("red", red, 1'b1);
    chk("grn", grn, 1'b0);
  endtask
  task automatic t_ce;
    cyc(12);
    spulse(4'h2);
    ce <= 1'b0;
    cyc(20);
    chk("frz", grn, 1'b1);
    ce <= 1'b1;
    cyc(8);
    chk("grn", grn, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_net;
    t_regs;
    t_good;
    t_exc;
    t_tmo;
    t_crc;
    t_route;
    t_dis;
    t_slave;
    t_ce;
    print_verdict();
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
endmodule
bind mfs_top mfs_checker #(.PULSE_CYC(PULSE_CYC), .TICK_CYC(TICK_CYC)) u_mfs_checker (
  .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .MST_ATTEMPT(MST_ATTEMPT), .SLV_REQ_RX(SLV_REQ_RX),
  .SLV_RSP_GOOD(SLV_RSP_GOOD), .SLV_RSP_EXC(SLV_RSP_EXC), .SRV_RUN(SRV_RUN),
  .LINK_UP(LINK_UP), .MST_SEND(MST_SEND), .MST_ABORT(MST_ABORT), .REQ_YELLOW(REQ_YELLOW),
  .RPL_GREEN(RPL_GREEN), .RPL_RED(RPL_RED), .NET_LED(NET_LED), .LINK_LED(LINK_LED)
);
`default_nettype wire
